/* File: hdl/sub_exec_unit.sv */
// Subtract and conditional-divide execution unit with APB registers
//
// What this block does
// - Pointer subtract: 3-bit register, 7-bit immediate
// - Pointer minus zero-extended immediate, flags untouched
// - Non-repeatable ops clear repeat count, run once
// - Borrow subtract sets zero and negative
// - Old carry used; borrow clears, else sets
// - Overflow flag sets, never cleared by hardware
// - Counter tracks overflow direction unless saturating
// - 16-bit step: shift, compare, subtract plus one
// - 16-bit step flags from final sum
// - 16-bit step carry from temporary borrow
// - Single 16-bit step keeps overflow state
// - Sixteen steps leave remainder and quotient
// - 32-bit step works on sum:product pair
// - 32-bit step shifts pair, inserts quotient bit
// - 32-bit step flags final, overflow kept unless repeated
`timescale 1ns/1ps
`default_nettype none
module sub_exec_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // Architectural state
  logic [31:0] acc_reg;
  logic [31:0] p_reg;
  logic [31:0] opnd_reg;
  logic [31:0] aux_reg [8];
  subx_pkg::flags_s flags_reg;
  logic sat_reg;
  logic [15:0] rpt_cnt_reg;
  logic rpt_pend_reg;
  // Sequencer state
  subx_pkg::exec_state_e state_reg;
  logic wide_reg;
  logic rep_reg;
  // Read path state
  logic [31:0] prdata_reg;
  logic loaded_reg;

  // Next values
  logic [31:0] acc_next;
  logic [31:0] p_next;
  logic [31:0] aux_next [8];
  subx_pkg::flags_s flags_next;
  logic [15:0] rpt_cnt_next;
  logic rpt_pend_next;
  subx_pkg::exec_state_e state_next;

  // Address decode
  wire logic hit_acc = paddr == subx_pkg::ACC_OFS;
  wire logic hit_p = paddr == subx_pkg::P_OFS;
  wire logic hit_opnd = paddr == subx_pkg::OPND_OFS;
  wire logic hit_instr = paddr == subx_pkg::INSTR_OFS;
  wire logic hit_status = paddr == subx_pkg::STATUS_OFS;
  wire logic hit_mode = paddr == subx_pkg::MODE_OFS;
  wire logic hit_rpt = paddr == subx_pkg::RPT_OFS;
  wire logic hit_aux = (paddr[7:5] == subx_pkg::AUX_OFS[7:5]) &&
    (paddr[1:0] == 2'b00);
  wire logic [2:0] aux_idx = paddr[4:2];
  wire logic mapped = hit_acc | hit_p | hit_opnd | hit_instr |
    hit_status | hit_mode | hit_rpt | hit_aux;

  // Busy sequencer stalls every access until it is idle again
  wire logic run = state_reg == subx_pkg::EXEC_RUN;
  wire logic idle = state_reg == subx_pkg::EXEC_IDLE;
  assign pready = penable && idle && loaded_reg;
  assign pslverr = pready && !mapped;
  assign prdata = prdata_reg;
  wire logic done = psel && penable && pready;
  wire logic wr_en = done && pwrite && mapped;
  wire logic wr_status = wr_en && hit_status;
  wire logic wr_rpt = wr_en && hit_rpt;

  // Instruction decode on a write to the instruction register
  wire logic op_wr = wr_en && hit_instr;
  wire logic pad16 = pwdata[31:16] == subx_pkg::OP16_PAD;
  wire logic dec_imm = pad16 && pwdata[15:11] == subx_pkg::IMM_OP_HI &&
    pwdata[subx_pkg::IMM_MARK_BIT];
  wire logic dec_c16 = pad16 &&
    pwdata[15:8] == subx_pkg::COND16_OP;
  wire logic dec_c32 = pwdata[31:8] == subx_pkg::COND32_OP;
  wire logic dec_brw = pwdata[31:8] == subx_pkg::BORROW_OP;
  wire logic imm_do = op_wr && dec_imm;
  wire logic brw_do = op_wr && dec_brw;
  wire logic start_rep = op_wr && (dec_c16 || dec_c32);
  // Register select and immediate fields of the pointer form
  wire logic [2:0] imm_sel = pwdata[subx_pkg::IMM_REG_LSB +: 3];
  wire logic [6:0] imm_val = pwdata[6:0];

  // Arithmetic units
  subx_pkg::step_res_s step_res;
  subx_pkg::step_res_s brw_res;

  cond_sub_step u_step (
    .acc(acc_reg),
    .p(p_reg),
    .operand(opnd_reg),
    .wide(wide_reg),
    .res(step_res)
  );

  borrow_sub u_brw (
    .acc(acc_reg),
    .operand(opnd_reg),
    .carry(flags_reg.c),
    .sat(sat_reg),
    .res(brw_res)
  );

  // Sum register: borrow op, division step, or software write
  assign acc_next = brw_do ? brw_res.acc :
    run ? step_res.acc :
    (wr_en && hit_acc) ? pwdata : acc_reg;
  // Product register moves in the 32-bit step or on a software write
  assign p_next = run ? step_res.p :
    (wr_en && hit_p) ? pwdata : p_reg;

  // Flag events; step overflow counts only inside a repeated step run, borrow overflow always
  wire logic arith = brw_do || run;
  wire logic step_ovf = run && rep_reg && step_res.ovf;
  wire logic ovf_ev = (brw_do && brw_res.ovf) || step_ovf;
  wire logic ovf_pos = brw_do ? brw_res.pos_ovf : step_res.pos_ovf;
  wire logic cnt_ev = ovf_ev && !sat_reg;
  wire logic [5:0] ovc_step = ovf_pos ? flags_reg.ovc + 6'h01 :
    flags_reg.ovc - 6'h01;
  wire logic new_c = brw_do ? ~brw_res.borrow :
    ~step_res.borrow;

  // Hardware events win over a software status write
  assign flags_next.c = arith ? new_c :
    wr_status ? pwdata[subx_pkg::ST_C_BIT] : flags_reg.c;
  assign flags_next.z = arith ? (acc_next == 32'h0000_0000) :
    wr_status ? pwdata[subx_pkg::ST_Z_BIT] : flags_reg.z;
  assign flags_next.n = arith ? acc_next[31] :
    wr_status ? pwdata[subx_pkg::ST_N_BIT] : flags_reg.n;
  assign flags_next.v = ovf_ev ? 1'b1 :
    wr_status ? pwdata[subx_pkg::ST_V_BIT] : flags_reg.v;
  assign flags_next.ovc = cnt_ev ? ovc_step :
    wr_status ? pwdata[subx_pkg::ST_OVC_LSB +: subx_pkg::OVC_W] :
    flags_reg.ovc;

  // Pointer registers, one per index
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_aux
      wire logic sel_imm = imm_do && (imm_sel == 3'(gi));
      wire logic sel_wr = wr_en && hit_aux && (aux_idx == 3'(gi));
      assign aux_next[gi] = sel_imm ?
        aux_reg[gi] - {25'h000_0000, imm_val} :
        sel_wr ? pwdata : aux_reg[gi];
      // Pointer storage
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          aux_reg[gi] <= subx_pkg::AUX_RST;
        end else begin
          aux_reg[gi] <= aux_next[gi];
        end
      end
    end
  endgenerate

  // Repeat counter doubles as the remaining-step counter
  wire logic last_step = run && rpt_cnt_reg == 16'h0000;
  assign rpt_cnt_next = wr_rpt ? pwdata[15:0] :
    (imm_do || brw_do) ? 16'h0000 :
    start_rep ? (rpt_pend_reg ? rpt_cnt_reg : 16'h0000) :
    (run && !last_step) ? rpt_cnt_reg - 16'h0001 : rpt_cnt_reg;
  assign rpt_pend_next = wr_rpt ? 1'b1 :
    (imm_do || brw_do || start_rep) ? 1'b0 : rpt_pend_reg;
  assign state_next = start_rep ? subx_pkg::EXEC_RUN :
    last_step ? subx_pkg::EXEC_IDLE : state_reg;

  // Read mux, sampled into a flop while idle
  wire logic [31:0] status_rd = {21'h00_0000, run, flags_reg.ovc,
    flags_reg.v, flags_reg.n, flags_reg.z, flags_reg.c};
  wire logic [31:0] rd_mux = hit_acc ? acc_reg :
    hit_p ? p_reg :
    hit_opnd ? opnd_reg :
    hit_status ? status_rd :
    hit_mode ? {31'h0000_0000, sat_reg} :
    hit_rpt ? {16'h0000, rpt_cnt_reg} :
    hit_aux ? aux_reg[aux_idx] : 32'h0000_0000;

  // Datapath registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= subx_pkg::ACC_RST;
      p_reg <= subx_pkg::P_RST;
      opnd_reg <= subx_pkg::OPND_RST;
      flags_reg <= {subx_pkg::OVC_RST, 4'h0};
    end else begin
      acc_reg <= acc_next;
      p_reg <= p_next;
      opnd_reg <= (wr_en && hit_opnd) ? pwdata : opnd_reg;
      flags_reg <= flags_next;
    end
  end

  // Mode, repeat and sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_reg <= subx_pkg::MODE_RST;
      rpt_cnt_reg <= subx_pkg::RPT_RST;
      rpt_pend_reg <= 1'b0;
      state_reg <= subx_pkg::EXEC_IDLE;
      wide_reg <= 1'b0;
      rep_reg <= 1'b0;
    end else begin
      sat_reg <= (wr_en && hit_mode) ? pwdata[subx_pkg::MODE_SAT_BIT] :
        sat_reg;
      rpt_cnt_reg <= rpt_cnt_next;
      rpt_pend_reg <= rpt_pend_next;
      state_reg <= state_next;
      wide_reg <= start_rep ? dec_c32 : wide_reg;
      rep_reg <= start_rep ? rpt_pend_reg : rep_reg;
    end
  end

  // Read data sampled each idle cycle with psel; loaded flag cleared when the transfer completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      loaded_reg <= 1'b0;
    end else begin
      prdata_reg <= (psel && idle) ? rd_mux : prdata_reg;
      loaded_reg <= psel && idle && !done;
    end
  end

  // Checks on the datapath and sequencer
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [31:0] imm_old;
  assign imm_old = aux_reg[imm_sel];

  sequence s_single_start;
    start_rep && !rpt_pend_reg;
  endsequence

  sequence s_four_steps;
    run [*4] ##1 !run;
  endsequence

  AST_IMM_WRITEBACK: assert property (
    imm_do |=> aux_reg[$past(imm_sel)] ==
      $past(imm_old) - {25'h000_0000, $past(imm_val)})
    else $error("pointer subtract result wrong");
  AST_IMM_FLAGS_KEPT: assert property (
    imm_do |=> flags_reg == $past(flags_reg))
    else $error("pointer subtract changed flags");
  AST_NO_REPEAT: assert property (
    (op_wr && (dec_imm || dec_brw)) |=>
      (rpt_cnt_reg == 16'h0000 && !rpt_pend_reg && idle))
    else $error("non-repeatable op left repeat state");
  AST_BORROW_CARRY: assert property (
    brw_do |=> flags_reg.c == ({1'b0, $past(acc_reg)} >=
      {1'b0, $past(opnd_reg)} + {32'h0000_0000, !$past(flags_reg.c)}))
    else $error("borrow subtract carry wrong");
  AST_ZN_FINAL: assert property (
    arith |=> (flags_reg.z == (acc_reg == 32'h0000_0000)) &&
      (flags_reg.n == acc_reg[31]))
    else $error("zero or negative flag mismatch");
  AST_V_STICKY: assert property (
    (flags_reg.v && !wr_status) |=> flags_reg.v)
    else $error("overflow flag dropped");
  AST_SAT_CLAMP: assert property (
    (brw_do && sat_reg && brw_res.ovf) |=>
      (acc_reg == subx_pkg::MAX_POS || acc_reg == subx_pkg::MAX_NEG))
    else $error("saturation did not clamp");
  AST_OVC_SAT_HOLD: assert property (
    (sat_reg && !wr_status) |=> flags_reg.ovc == $past(flags_reg.ovc))
    else $error("counter moved while saturating");
  AST_SINGLE_KEEPS_V: assert property (
    s_single_start |-> ##2 (idle && flags_reg.v == $past(flags_reg.v, 2)
      && flags_reg.ovc == $past(flags_reg.ovc, 2)))
    else $error("single step changed overflow state");
  AST_REPEAT_LENGTH: assert property (
    (start_rep && rpt_pend_reg && rpt_cnt_reg == 16'h0003) |=>
      s_four_steps)
    else $error("repeat count not honoured");
  AST_STALL_BUSY: assert property (
    run |-> !pready)
    else $error("access completed while busy");
endmodule
`default_nettype wire

/* File: shared/subx_pkg.sv */
// Constants, encodings and carriers shared by the subtract execution unit
package subx_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] ACC_OFS = 8'h00;
  localparam logic [7:0] P_OFS = 8'h04;
  localparam logic [7:0] OPND_OFS = 8'h08;
  localparam logic [7:0] INSTR_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MODE_OFS = 8'h14;
  localparam logic [7:0] RPT_OFS = 8'h18;
  localparam logic [7:0] AUX_OFS = 8'h20;
  // Reset values
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [31:0] P_RST = 32'h0000_0000;
  localparam logic [31:0] OPND_RST = 32'h0000_0000;
  localparam logic [31:0] AUX_RST = 32'h0000_0000;
  localparam logic [15:0] RPT_RST = 16'h0000;
  localparam logic [5:0] OVC_RST = 6'h00;
  localparam logic MODE_RST = 1'b0;
  // Status register field positions
  localparam int ST_C_BIT = 0;
  localparam int ST_Z_BIT = 1;
  localparam int ST_N_BIT = 2;
  localparam int ST_V_BIT = 3;
  localparam int ST_OVC_LSB = 4;
  localparam int OVC_W = 6;
  localparam int ST_BUSY_BIT = 10;
  // Mode register field position
  localparam int MODE_SAT_BIT = 0;
  // Opcode encodings
  localparam logic [4:0] IMM_OP_HI = 5'h1B;
  localparam int IMM_MARK_BIT = 7;
  localparam int IMM_REG_LSB = 8;
  localparam logic [15:0] OP16_PAD = 16'h0000;
  localparam logic [7:0] COND16_OP = 8'h1F;
  localparam logic [23:0] COND32_OP = 24'h56_1700;
  localparam logic [23:0] BORROW_OP = 24'h56_5400;
  // Saturation limits
  localparam logic [31:0] MAX_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] MAX_NEG = 32'h8000_0000;

  // Sequencer states
  typedef enum logic [0:0] {
    EXEC_IDLE = 1'b0,
    EXEC_RUN = 1'b1
  } exec_state_e;

  // Result of one arithmetic step
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] p;
    logic borrow;
    logic ovf;
    logic pos_ovf;
  } step_res_s;

  // Status flags as one group
  typedef struct packed {
    logic [5:0] ovc;
    logic v;
    logic n;
    logic z;
    logic c;
  } flags_s;
endpackage

/* File: hdl/cond_sub_step.sv */
// One conditional-subtract division step, 16-bit or 32-bit form
`timescale 1ns/1ps
`default_nettype none
module cond_sub_step (
  input wire logic [31:0] acc,
  input wire logic [31:0] p,
  input wire logic [31:0] operand,
  input wire logic wide,
  output subx_pkg::step_res_s res
);
  // Extra top bit turns the 33-bit temporary's sign into a borrow
  logic [33:0] diff16;
  logic [33:0] diff32;
  logic borrow;
  logic [31:0] acc16;
  logic [31:0] acc32;
  logic [31:0] p32;

  // Sum shifted left minus divisor placed in the upper half
  assign diff16 = {1'b0, acc, 1'b0} - {2'b00, operand[15:0], 16'h0000};
  // Pair shifted left minus full-width divisor
  assign diff32 = {1'b0, acc, p[31]} - {2'b00, operand};
  assign borrow = wide ? diff32[33] : diff16[33];
  // Quotient bit lands in bit 0 on success
  // Sixteen of these leave remainder high, quotient low
  assign acc16 = borrow ? {acc[30:0], 1'b0} : diff16[31:0] + 32'h0000_0001;
  assign acc32 = borrow ? {acc[30:0], p[31]} : diff32[31:0];
  assign p32 = borrow ? {p[30:0], 1'b0} : {p[30:0], 1'b1};

  // Shift of the sum loses its sign when bits 31 and 30 differ
  assign res.acc = wide ? acc32 : acc16;
  assign res.p = wide ? p32 : p;
  assign res.borrow = borrow;
  assign res.ovf = acc[31] ^ acc[30];
  assign res.pos_ovf = ~acc[31];
endmodule
`default_nettype wire

/* File: hdl/borrow_sub.sv */
// 32-bit subtract with inverse borrow and optional saturation
`timescale 1ns/1ps
`default_nettype none
module borrow_sub (
  input wire logic [31:0] acc,
  input wire logic [31:0] operand,
  input wire logic carry,
  input wire logic sat,
  output subx_pkg::step_res_s res
);
  logic [32:0] diff;
  logic [31:0] raw;
  logic ovf;

  // Old carry low means one extra to take away
  assign diff = {1'b0, acc} - {1'b0, operand} - {32'h0000_0000, ~carry};
  assign raw = diff[31:0];
  // Overflow only when operand signs differ and result flips sign
  assign ovf = (acc[31] != operand[31]) && (raw[31] != acc[31]);

  // Clamp toward the side the true result lies on
  assign res.acc = (sat && ovf) ?
    (acc[31] ? subx_pkg::MAX_NEG : subx_pkg::MAX_POS) : raw;
  assign res.p = 32'h0000_0000;
  assign res.borrow = diff[32];
  assign res.ovf = ovf;
  assign res.pos_ovf = ~acc[31];
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking APB bench for the subtract execution unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LIMIT = 20000; // Watchdog; the tests need about 650
  logic pclk; // 125 MHz bus clock
  logic presetn; // Async reset, low active
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_mismatch; // Failed comparisons
  int checks_done; // All comparisons
  int cycles; // Watchdog count
  int k; // Loop index
  logic [31:0] rd_data; // Data of last transfer
  logic rd_err; // Error response of last transfer

  sub_exec_unit u_sub_exec_unit (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // Free-running clock
  always #4 pclk = ~pclk;

  // Watchdog, so a stalled access cannot hang the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  // Verdict and end of run
  task automatic close_out();
    $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; held until pready is seen, busy runs stall it
  // Request is held to the rising edge that sees pready, then released
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input logic [7:0] a);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t addr %h got %h exp %h", $time, a, got,
               exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd_data, exp, a);
  endtask

  // Subtract with borrow, expected values worked out here
  task automatic borrow_case(input logic [31:0] acc,
    input logic [31:0] op, input logic [9:0] st, input logic sat);
    logic [32:0] diff;
    logic [31:0] r;
    logic ovf;
    logic pos;
    subx_pkg::flags_s f;
    f = st;
    diff = {1'b0, acc} - {1'b0, op} - {32'h0, ~f.c};
    r = diff[31:0];
    ovf = (acc[31] != op[31]) && (r[31] != acc[31]);
    pos = ovf && !acc[31];
    if (sat && ovf) r = pos ? subx_pkg::MAX_POS : subx_pkg::MAX_NEG;
    f.c = !diff[32];
    f.z = (r == 32'h0000_0000);
    f.n = r[31];
    f.v = f.v | ovf;
    if (!sat && ovf) f.ovc = pos ? f.ovc + 6'h01 : f.ovc - 6'h01;
    wr(subx_pkg::MODE_OFS, {31'h0, sat});
    wr(subx_pkg::ACC_OFS, acc);
    wr(subx_pkg::OPND_OFS, op);
    wr(subx_pkg::STATUS_OFS, {22'h0, st});
    wr(subx_pkg::RPT_OFS, 32'h0000_0003);
    wr(subx_pkg::INSTR_OFS, {subx_pkg::BORROW_OP, 8'h00});
    rchk(subx_pkg::ACC_OFS, r);
    rchk(subx_pkg::STATUS_OFS, {22'h0, f});
    rchk(subx_pkg::RPT_OFS, 32'h0000_0000);
  endtask

  // Conditional-subtract run with a stepwise reference
  task automatic cdiv(input logic wide, input logic [31:0] acc,
    input logic [31:0] p, input logic [31:0] op, input logic [15:0] n,
    input logic armed, input logic [9:0] st);
    logic [32:0] t;
    subx_pkg::flags_s f;
    int i;
    f = st;
    wr(subx_pkg::MODE_OFS, 32'h0000_0000);
    wr(subx_pkg::ACC_OFS, acc);
    wr(subx_pkg::P_OFS, p);
    wr(subx_pkg::OPND_OFS, op);
    wr(subx_pkg::STATUS_OFS, {22'h0, st});
    if (armed) wr(subx_pkg::RPT_OFS, {16'h0, n});
    if (wide) begin
      wr(subx_pkg::INSTR_OFS, {subx_pkg::COND32_OP, 8'h00});
    end else begin
      wr(subx_pkg::INSTR_OFS, {16'h0, subx_pkg::COND16_OP, 8'h00});
    end
    for (i = 0; i <= (armed ? int'(n) : 0); i++) begin
      // Intermediate overflow only counts in a repeated run
      if (armed && (acc[31] != acc[30])) begin
        f.v = 1'b1;
        f.ovc = acc[31] ? f.ovc - 6'h01 : f.ovc + 6'h01;
      end
      if (wide) begin
        t = {acc, p[31]} - {1'b0, op};
        {acc, p} = t[32] ? {acc, p} << 1 : {t[31:0], p[30:0], 1'b1};
      end else begin
        t = {acc, 1'b0} - {1'b0, op[15:0], 16'h0000};
        acc = t[32] ? acc << 1 : t[31:0] + 32'h0000_0001;
      end
      f.c = !t[32];
    end
    f.z = (acc == 32'h0000_0000);
    f.n = acc[31];
    rchk(subx_pkg::ACC_OFS, acc);
    rchk(subx_pkg::P_OFS, p);
    rchk(subx_pkg::STATUS_OFS, {22'h0, f});
    rchk(subx_pkg::RPT_OFS, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rchk(subx_pkg::ACC_OFS, subx_pkg::ACC_RST);
    rchk(subx_pkg::P_OFS, subx_pkg::P_RST);
    rchk(subx_pkg::STATUS_OFS, 32'h0000_0000);
    rchk(subx_pkg::MODE_OFS, 32'h0000_0000);
    rchk(subx_pkg::RPT_OFS, 32'h0000_0000);
    rchk(subx_pkg::AUX_OFS + 8'h1C, subx_pkg::AUX_RST);
    rchk(subx_pkg::INSTR_OFS, 32'h0000_0000);
    // Unmapped address refused both ways
    xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
    chk({31'h0, rd_err}, 32'h0000_0001, 8'h1C);
    xfer(1'b0, 8'h1C, 32'h0000_0000);
    chk({rd_data[31:1], rd_err}, 32'h0000_0001, 8'h1C);
    // Pointer subtract on every register, flags preset all high
    wr(subx_pkg::STATUS_OFS, 32'h0000_03FF);
    for (k = 0; k < 8; k++) begin
      wr(subx_pkg::AUX_OFS + 8'(4 * k), 32'h0000_0010 + 32'(k));
      wr(subx_pkg::RPT_OFS, 32'h0000_0005);
      wr(subx_pkg::INSTR_OFS, {16'h0, subx_pkg::IMM_OP_HI, 3'(k), 1'b1,
         7'(7'h7F >> k)});
      rchk(subx_pkg::AUX_OFS + 8'(4 * k),
           32'h0000_0010 + 32'(k) - 32'(7'h7F >> k));
      rchk(subx_pkg::RPT_OFS, 32'h0000_0000);
    end
    rchk(subx_pkg::STATUS_OFS, 32'h0000_03FF);
    // Borrow subtract: carry in, sticky V, counter, saturation
    borrow_case(32'h5, 32'h3, 10'h001, 1'b0);
    borrow_case(32'h5, 32'h3, 10'h008, 1'b0);
    borrow_case(32'h0, 32'h0, 10'h001, 1'b0);
    borrow_case(32'h0, 32'h0, 10'h000, 1'b0);
    borrow_case(32'h0, 32'h1, 10'h001, 1'b0);
    borrow_case(32'h7FFF_FFFF, 32'hFFFF_FFFF, 10'h001, 1'b0);
    borrow_case(32'h8000_0000, 32'h1, 10'h001, 1'b0);
    borrow_case(32'h7FFF_FFFF, 32'hFFFF_FFFF, 10'h051, 1'b1);
    borrow_case(32'h8000_0000, 32'h1, 10'h051, 1'b1);
    // Sixteen 16-bit steps give remainder and quotient, then overflow in one and two steps
    cdiv(1'b0, 32'h0000_BEEF, 32'h1234_5678, 32'hAB, 16'd15, 1'b1,
         10'h000);
    rchk(subx_pkg::ACC_OFS, {16'hBEEF % 16'h00AB,
         16'hBEEF / 16'h00AB});
    cdiv(1'b0, 32'h4000_0000, 32'h0, 32'h1, 16'd0, 1'b0,
         10'h050);
    cdiv(1'b0, 32'h4000_0000, 32'h0, 32'h1, 16'd1, 1'b1,
         10'h050);
    // Repeat of three gives exactly four busy steps
    cdiv(1'b0, 32'h0000_0064, 32'h0, 32'h7, 16'd3, 1'b1,
         10'h000);
    // Thirty-two 32-bit steps on the pair, then one single step
    cdiv(1'b1, 32'h0, 32'hDEAD_BEEF, 32'h1234, 16'd31, 1'b1,
         10'h050);
    rchk(subx_pkg::P_OFS, 32'hDEAD_BEEF / 32'h1234);
    cdiv(1'b1, 32'h0000_0001, 32'h8000_0000, 32'h3, 16'd0, 1'b0,
         10'h058);
    close_out();
  end
endmodule
`default_nettype wire
